// >>> core/btr_core.sv
// core-side controller: APB registers for software, feeds bits and services vectors
`timescale 1ns/1ps
module btr_core (
	// link to the device
	btr_link_if.core lnk,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef enum logic [2:0] {HS_IDLE, HS_ST_CNT, HS_ST_CTRL, HS_RAW, HS_ISR_CTRL, HS_ISR_CLR,
		HS_RETI} btr_hs_e;

	logic clk;
	logic rst_n;
	logic [1:0] mode_q;
	logic gie_q, busy_q, btn_q;
	logic [15:0] bits_q, word0_q;
	logic [9:0] cv_q;
	logic [4:0] len_q;
	logic [10:0] raw_q;
	btr_hs_e hs_q;
	logic wr_q, reti_q, done_q, in_isr_q;
	logic [1:0] addr_q;
	logic [7:0] wdata_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic apb_wr, start, hit, raw_go;
	logic [7:0] ctrl_bits;

	assign clk = lnk.pclk;
	assign rst_n = lnk.presetn;
	assign apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;
	assign start = apb_wr && paddr == btr_pkg::H_CTRL && pwdata[btr_pkg::HC_START] &&
		hs_q == HS_IDLE;
	assign raw_go = apb_wr && paddr == btr_pkg::H_RAW && !pwdata[btr_pkg::HR_RDONLY];
	assign hit = (paddr == btr_pkg::H_CTRL) || (paddr == btr_pkg::H_BITS) ||
		(paddr == btr_pkg::H_CVAL) || (paddr == btr_pkg::H_LEN) ||
		(paddr == btr_pkg::H_WORD0) || (paddr == btr_pkg::H_RAW) || (paddr == btr_pkg::H_STAT);
	// both interrupt enables on; data bit is the next bit to send
	assign ctrl_bits = {cv_q[9:8], mode_q, 1'b1, 1'b1, 1'b0, bits_q[0]};

	// =====================================================
	// APB: no wait states, error on unmapped or raw write while busy
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			pready_q <= psel && !penable;
			if (psel && !penable)
			begin
				pslverr_q <= !hit || (pwrite && paddr == btr_pkg::H_RAW && hs_q != HS_IDLE);
				case (paddr)
					btr_pkg::H_CTRL:
						prdata_q <= {26'h0, busy_q, 2'h0, gie_q, mode_q};
					btr_pkg::H_BITS:
						prdata_q <= {16'h0, bits_q};
					btr_pkg::H_CVAL:
						prdata_q <= {22'h0, cv_q};
					btr_pkg::H_LEN:
						prdata_q <= {27'h0, len_q};
					btr_pkg::H_WORD0:
						prdata_q <= {16'h0, word0_q};
					btr_pkg::H_RAW:
						prdata_q <= {24'h0, lnk.reg_rdata};
					btr_pkg::H_STAT:
						prdata_q <= {16'h0, lnk.reg_rdata, 4'h0, lnk.reg_ready,
							hs_q != HS_IDLE, in_isr_q, lnk.core_run};
					default:
						prdata_q <= 32'h00000000;
				endcase
			end
			else
				pslverr_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= btr_pkg::MODE_OFF;
			gie_q <= 1'b0;
			busy_q <= 1'b0;
			btn_q <= 1'b0;
			cv_q <= 10'h000;
			word0_q <= 16'h0000;
			raw_q <= 11'h000;
		end
		else
		begin
			btn_q <= apb_wr && paddr == btr_pkg::H_CTRL && pwdata[btr_pkg::HC_BTN];
			if (apb_wr && paddr == btr_pkg::H_CTRL)
			begin
				mode_q <= pwdata[btr_pkg::HC_MODE+1:btr_pkg::HC_MODE];
				gie_q <= pwdata[btr_pkg::HC_GIE];
				busy_q <= pwdata[btr_pkg::HC_BUSY];
			end
			else if (hs_q == HS_ISR_CTRL && lnk.irq_vector == btr_pkg::VEC_TRANSMISSION_COMPLETE)
				mode_q <= btr_pkg::MODE_OFF;
			if (apb_wr && paddr == btr_pkg::H_CVAL)
				cv_q <= pwdata[9:0];
			if (apb_wr && paddr == btr_pkg::H_WORD0)
				word0_q <= pwdata[15:0];
			if (apb_wr && paddr == btr_pkg::H_RAW)
				raw_q <= pwdata[10:0];
		end
	end

	// =====================================================
	// sequencer: start-up writes and interrupt service
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hs_q <= HS_IDLE;
			wr_q <= 1'b0;
			addr_q <= btr_pkg::REG_CTRL;
			wdata_q <= 8'h00;
			reti_q <= 1'b0;
			in_isr_q <= 1'b0;
			bits_q <= 16'h0000;
			len_q <= 5'h00;
		end
		else
		begin
			reti_q <= 1'b0;
			if (apb_wr && paddr == btr_pkg::H_BITS && hs_q == HS_IDLE)
				bits_q <= pwdata[15:0];
			if (apb_wr && paddr == btr_pkg::H_LEN && hs_q == HS_IDLE)
				len_q <= pwdata[4:0];
			if (lnk.isr_start)
				in_isr_q <= 1'b1;
			if (wr_q && lnk.reg_ready)
				wr_q <= 1'b0;
			case (hs_q)
				HS_IDLE:
					if (lnk.isr_start)
						hs_q <= HS_ISR_CTRL;
					else if (start)
					begin
						hs_q <= HS_ST_CNT;
						wr_q <= 1'b1;
						addr_q <= btr_pkg::REG_CNT;
						wdata_q <= cv_q[7:0];
					end
					else if (raw_go)
					begin
						hs_q <= HS_RAW;
						wr_q <= 1'b1;
						addr_q <= pwdata[9:8];
						wdata_q <= pwdata[7:0];
					end
					else if (apb_wr && paddr == btr_pkg::H_RAW)
						addr_q <= pwdata[9:8];
				HS_ST_CNT:
					if (lnk.reg_ready)
					begin
						hs_q <= HS_ST_CTRL;
						wr_q <= 1'b1;
						addr_q <= btr_pkg::REG_CTRL;
						wdata_q <= ctrl_bits;
						// length counts the bits after this first one
						bits_q <= bits_q >> 1;
					end
				HS_ST_CTRL, HS_RAW:
					if (lnk.reg_ready)
						hs_q <= HS_IDLE;
				HS_ISR_CTRL:
				begin
					hs_q <= HS_ISR_CLR;
					if (lnk.irq_vector == btr_pkg::VEC_TRANSMISSION_COMPLETE)
					begin
						wr_q <= 1'b1;
						addr_q <= btr_pkg::REG_CTRL;
						wdata_q <= {cv_q[9:8], btr_pkg::MODE_OFF, 4'h0};
					end
					else if (len_q != 5'h00)
					begin
						wr_q <= 1'b1;
						addr_q <= btr_pkg::REG_CTRL;
						wdata_q <= ctrl_bits;
						bits_q <= bits_q >> 1;
						len_q <= len_q - 5'h01;
					end
				end
				HS_ISR_CLR:
					if (!wr_q || lnk.reg_ready)
					begin
						hs_q <= HS_RETI;
						wr_q <= 1'b1;
						addr_q <= btr_pkg::REG_FLAG;
						wdata_q <= (lnk.irq_vector == btr_pkg::VEC_TRANSMISSION_COMPLETE) ? 8'h04 : 8'h01;
					end
				HS_RETI:
					if (lnk.reg_ready)
					begin
						hs_q <= HS_IDLE;
						reti_q <= 1'b1;
						in_isr_q <= 1'b0;
					end
				default:
					hs_q <= HS_IDLE;
			endcase
		end
	end

	// main flow retires one instruction per cycle outside a handler
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			done_q <= 1'b0;
		else
			done_q <= lnk.core_run && !in_isr_q && !lnk.isr_start;
	end

	// =====================================================
	// outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign lnk.reg_wr = wr_q;
	assign lnk.reg_addr = addr_q;
	assign lnk.reg_wdata = wdata_q;
	assign lnk.gie = gie_q;
	assign lnk.instr_busy = busy_q;
	assign lnk.instr_done = done_q;
	assign lnk.reti = reti_q;
	assign lnk.button_cmd = btn_q;
	assign lnk.word0 = word0_q;
endmodule : btr_core

// >>> core/btr_device.sv
// bit timer device: slot timing, receive capture, flags, vectoring and reset sequencing
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module btr_device #(
	parameter int POR_DELAY = btr_pkg::POR_DELAY_CYC
) (
	// link to the core
	btr_link_if.dev lnk,
	// pins
	input wire logic pulse_input_pin,
	input wire logic external_reset_n,
	input wire logic watchdog_reset,
	input wire logic brownout,
	input wire logic button_pin,
	output logic rf_key
);
	localparam int DLY_W = $clog2(POR_DELAY + 1);

	typedef enum logic [2:0] {RS_POR, RS_CHECK, RS_RUN, RS_NOPROG, RS_EXT, RS_BROWN, RS_BUTTON}
		btr_rst_e;
	typedef enum logic [2:0] {IS_IDLE, IS_FINISH, IS_ENTRY, IS_JUMP, IS_ISR, IS_RET, IS_ONE}
		btr_irq_e;

	logic clk;
	logic rst_n;
	btr_rst_e rst_q, rst_d;
	logic [DLY_W-1:0] dly_q;
	logic core_run_q, fetch_start_q, reg_ready_q;
	logic io_clr;
	logic [7:0] ctrl_q, cnt_lo_q, rdata_q;
	logic flag0_q, flag2_q, pend_q;
	logic [btr_pkg::CV_W-1:0] cnt_q;
	logic active_q, key_q, pin_q;
	logic [1:0] mode;
	logic wr_ok, ctrl_wr, take, slot_end, rx_edge, set2, req;
	btr_irq_e is_q, is_d;
	logic [2:0] st_q;
	logic [7:0] vec_q;
	logic push_q, pop_q, isr_start_q;

	assign clk = lnk.pclk;
	assign rst_n = lnk.presetn;

	// =====================================================
	// reset sequencing
	always_comb
	begin
		rst_d = rst_q;
		if (!external_reset_n)
			rst_d = RS_EXT;
		else if (brownout)
			rst_d = RS_BROWN;
		else if (watchdog_reset)
			rst_d = RS_CHECK;
		else
		begin
			case (rst_q)
				RS_POR:
					if (dly_q == DLY_W'(POR_DELAY - 1))
						rst_d = RS_CHECK;
				RS_EXT:
					rst_d = RS_CHECK;
				RS_BROWN:
					rst_d = RS_CHECK;
				RS_CHECK:
					rst_d = btr_pkg::is_jump(lnk.word0) ? RS_RUN : RS_NOPROG;
				RS_RUN:
					if (lnk.button_cmd)
						rst_d = RS_BUTTON;
				RS_BUTTON:
					if (button_pin)
						rst_d = RS_RUN;
				RS_NOPROG:
					rst_d = RS_NOPROG;
				default:
					rst_d = RS_POR;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_q <= RS_POR;
			dly_q <= '0;
			core_run_q <= 1'b0;
			fetch_start_q <= 1'b0;
			reg_ready_q <= 1'b0;
		end
		else
		begin
			rst_q <= rst_d;
			// one counter: startup delay in power-on, access delay in external reset
			if (rst_d != rst_q)
				dly_q <= '0;
			else if (rst_q == RS_POR)
				dly_q <= dly_q + DLY_W'(1);
			else if (rst_q == RS_EXT && dly_q != DLY_W'(btr_pkg::EXT_ACCESS_CLKS))
				dly_q <= dly_q + DLY_W'(1);
			core_run_q <= (rst_d == RS_RUN);
			fetch_start_q <= (rst_d == RS_RUN) && (rst_q == RS_CHECK);
			reg_ready_q <= (rst_d == RS_RUN) || (rst_d == RS_BUTTON) ||
				(rst_d == RS_EXT && rst_q == RS_EXT &&
				dly_q >= DLY_W'(btr_pkg::EXT_ACCESS_CLKS - 1));
		end
	end

	// button reset clears nothing, so it is not part of this
	assign io_clr = !external_reset_n || watchdog_reset || brownout;

	// =====================================================
	// register port
	assign wr_ok = lnk.reg_wr && reg_ready_q;
	assign ctrl_wr = wr_ok && (lnk.reg_addr == btr_pkg::REG_CTRL);
	assign mode = ctrl_q[btr_pkg::CTRL_MODE+1:btr_pkg::CTRL_MODE];
	assign rx_edge = (mode == btr_pkg::MODE_RX) && (pulse_input_pin != pin_q);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q <= btr_pkg::CTRL_RST;
			cnt_lo_q <= btr_pkg::CNT_RST;
		end
		else if (io_clr)
		begin
			ctrl_q <= btr_pkg::CTRL_RST;
			cnt_lo_q <= btr_pkg::CNT_RST;
		end
		else
		begin
			if (ctrl_wr)
				ctrl_q <= lnk.reg_wdata;
			if (wr_ok && lnk.reg_addr == btr_pkg::REG_CNT)
				cnt_lo_q <= lnk.reg_wdata;
			// a captured edge overrides a software write in the same cycle
			if (rx_edge)
			begin
				cnt_lo_q <= cnt_q[7:0];
				ctrl_q[btr_pkg::CTRL_CVHI+1:btr_pkg::CTRL_CVHI] <= cnt_q[9:8];
				ctrl_q[btr_pkg::CTRL_DATA] <= pulse_input_pin;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else
		begin
			case (lnk.reg_addr)
				btr_pkg::REG_CTRL:
					rdata_q <= ctrl_q;
				btr_pkg::REG_CNT:
					rdata_q <= cnt_lo_q;
				btr_pkg::REG_FLAG:
					rdata_q <= {5'h00, flag2_q, 1'b0, flag0_q};
				default:
					rdata_q <= 8'h00;
			endcase
		end
	end

	// =====================================================
	// bit timer
	assign slot_end = active_q && (cnt_q == '0);
	assign take = (mode == btr_pkg::MODE_TX) && pend_q && (!active_q || slot_end);
	assign set2 = ((mode == btr_pkg::MODE_TX) && slot_end && !pend_q) ||
		((mode == btr_pkg::MODE_GEN) && slot_end);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			active_q <= 1'b0;
			key_q <= 1'b0;
		end
		else if (io_clr || mode == btr_pkg::MODE_OFF)
		begin
			cnt_q <= '0;
			active_q <= 1'b0;
			key_q <= 1'b0;
		end
		else
		begin
			case (mode)
				btr_pkg::MODE_TX:
					if (take)
					begin
						cnt_q <= btr_pkg::count_value(ctrl_q, cnt_lo_q);
						key_q <= ctrl_q[btr_pkg::CTRL_DATA];
						active_q <= 1'b1;
					end
					else if (slot_end)
					begin
						active_q <= 1'b0;
						key_q <= 1'b0;
					end
					else if (active_q)
						cnt_q <= cnt_q - btr_pkg::CV_W'(1);
				btr_pkg::MODE_GEN:
				begin
					key_q <= 1'b0;
					active_q <= 1'b1;
					if (!active_q || slot_end)
						cnt_q <= btr_pkg::count_value(ctrl_q, cnt_lo_q);
					else
						cnt_q <= cnt_q - btr_pkg::CV_W'(1);
				end
				btr_pkg::MODE_RX:
				begin
					key_q <= 1'b0;
					active_q <= 1'b0;
					// restart per edge; saturates rather than wrapping on long pulses
					if (rx_edge)
						cnt_q <= '0;
					else if (cnt_q != '1)
						cnt_q <= cnt_q + btr_pkg::CV_W'(1);
				end
				default:
					cnt_q <= '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pin_q <= 1'b0;
		else
			pin_q <= pulse_input_pin;
	end

	// flags: hardware set wins over software clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_q <= 1'b0;
			flag0_q <= 1'b0;
			flag2_q <= 1'b0;
		end
		else if (io_clr)
		begin
			pend_q <= 1'b0;
			flag0_q <= 1'b0;
			flag2_q <= 1'b0;
		end
		else
		begin
			pend_q <= (pend_q && !take) || ctrl_wr;
			flag0_q <= (flag0_q && !(wr_ok && lnk.reg_addr == btr_pkg::REG_FLAG &&
				lnk.reg_wdata[btr_pkg::FLAG0_BIT])) || take;
			flag2_q <= (flag2_q && !(wr_ok && lnk.reg_addr == btr_pkg::REG_FLAG &&
				lnk.reg_wdata[btr_pkg::FLAG2_BIT])) || set2;
		end
	end

	// =====================================================
	// interrupt entry and return
	assign req = core_run_q && lnk.gie && ((flag0_q && ctrl_q[btr_pkg::CTRL_IE0]) ||
		(flag2_q && ctrl_q[btr_pkg::CTRL_IE2]));

	always_comb
	begin
		is_d = is_q;
		case (is_q)
			IS_IDLE:
				if (req)
					is_d = lnk.instr_busy ? IS_FINISH : IS_ENTRY;
			IS_FINISH:
				if (!req)
					is_d = IS_IDLE;
				else if (!lnk.instr_busy)
					is_d = IS_ENTRY;
			IS_ENTRY:
				if (st_q == 3'(btr_pkg::ENTRY_CLKS - 1))
					is_d = IS_JUMP;
			IS_JUMP:
				if (st_q == 3'(btr_pkg::JUMP_CLKS - 1))
					is_d = IS_ISR;
			IS_ISR:
				if (lnk.reti)
					is_d = IS_RET;
			IS_RET:
				if (st_q == 3'(btr_pkg::RETI_CLKS - 1))
					is_d = IS_ONE;
			IS_ONE:
				if (lnk.instr_done)
					is_d = IS_IDLE;
			default:
				is_d = IS_IDLE;
		endcase
		if (!core_run_q)
			is_d = IS_IDLE;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			is_q <= IS_IDLE;
			st_q <= 3'h0;
			vec_q <= 8'h00;
			push_q <= 1'b0;
			pop_q <= 1'b0;
			isr_start_q <= 1'b0;
		end
		else
		begin
			is_q <= is_d;
			st_q <= (is_d != is_q) ? 3'h0 : st_q + 3'h1;
			// done outranks buffer-empty: lower vector wins
			if (is_q == IS_IDLE && is_d != IS_IDLE)
				vec_q <= (flag2_q && ctrl_q[btr_pkg::CTRL_IE2]) ? btr_pkg::VEC_TRANSMISSION_COMPLETE :
					btr_pkg::VEC_BUFEMPTY;
			push_q <= (is_d == IS_ENTRY);
			pop_q <= (is_d == IS_RET);
			isr_start_q <= (is_d == IS_ISR) && (is_q != IS_ISR);
		end
	end

	// =====================================================
	// outputs
	assign rf_key = key_q;
	assign lnk.reg_rdata = rdata_q;
	assign lnk.reg_ready = reg_ready_q;
	assign lnk.irq_vector = vec_q;
	assign lnk.isr_start = isr_start_q;
	assign lnk.pc_push = push_q;
	assign lnk.pc_pop = pop_q;
	assign lnk.core_run = core_run_q;
	assign lnk.fetch_start = fetch_start_q;
endmodule : btr_device

// >>> shared/btr_link_if.sv
// link between the bit timer device and the core-side controller
`timescale 1ns/1ps
interface btr_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic reg_wr;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_ready;
	logic gie;
	logic instr_busy;
	logic instr_done;
	logic reti;
	logic button_cmd;
	logic [15:0] word0;
	logic [7:0] irq_vector;
	logic isr_start;
	logic pc_push;
	logic pc_pop;
	logic core_run;
	logic fetch_start;

	modport dev (
		input pclk, presetn, reg_wr, reg_addr, reg_wdata, gie, instr_busy, instr_done,
		input reti, button_cmd, word0,
		output reg_rdata, reg_ready, irq_vector, isr_start, pc_push, pc_pop, core_run,
		output fetch_start
	);
	modport core (
		input pclk, presetn, reg_rdata, reg_ready, irq_vector, isr_start, pc_push, pc_pop,
		input core_run, fetch_start,
		output reg_wr, reg_addr, reg_wdata, gie, instr_busy, instr_done, reti, button_cmd,
		output word0
	);
endinterface : btr_link_if

// >>> shared/btr_pkg.sv
// constants, register layout and helpers shared by both ends of the bit timer link
package btr_pkg;
	// =====================================================
	// device register port
	localparam int CV_W = 10;
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_CNT = 2'h1;
	localparam logic [1:0] REG_FLAG = 2'h2;
	localparam int CTRL_DATA = 0;
	localparam int CTRL_IE0 = 2;
	localparam int CTRL_IE2 = 3;
	localparam int CTRL_MODE = 4;
	localparam int CTRL_CVHI = 6;
	localparam int FLAG0_BIT = 0;
	localparam int FLAG2_BIT = 2;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_TX = 2'h1;
	localparam logic [1:0] MODE_RX = 2'h2;
	localparam logic [1:0] MODE_GEN = 2'h3;
	localparam logic [7:0] VEC_TRANSMISSION_COMPLETE = 8'h02;
	localparam logic [7:0] VEC_BUFEMPTY = 8'h04;
	// =====================================================
	// timing in system clock cycles
	localparam int POR_DELAY_CYC = 1000000;
	localparam int EXT_ACCESS_CLKS = 2;
	localparam int ENTRY_CLKS = 4;
	localparam int JUMP_CLKS = 2;
	localparam int RETI_CLKS = 4;
	// =====================================================
	// controller registers on APB
	localparam logic [7:0] H_CTRL = 8'h00;
	localparam logic [7:0] H_BITS = 8'h04;
	localparam logic [7:0] H_CVAL = 8'h08;
	localparam logic [7:0] H_LEN = 8'h0C;
	localparam logic [7:0] H_WORD0 = 8'h10;
	localparam logic [7:0] H_RAW = 8'h14;
	localparam logic [7:0] H_STAT = 8'h18;
	localparam int HC_MODE = 0;
	localparam int HC_GIE = 2;
	localparam int HC_START = 3;
	localparam int HC_BTN = 4;
	localparam int HC_BUSY = 5;
	localparam int HR_RDONLY = 10;

	// relative jump or absolute jump opcode at the reset address
	function automatic logic is_jump(input logic [15:0] w);
		is_jump = (w[15:12] == 4'hC) || ((w[15:9] == 7'h4A) && (w[3:1] == 3'h6));
	endfunction : is_jump

	function automatic logic [CV_W-1:0] count_value(input logic [7:0] ctrl, input logic [7:0] lo);
		count_value = {ctrl[CTRL_CVHI+1:CTRL_CVHI], lo};
	endfunction : count_value
endpackage : btr_pkg

// >>> tb/btr_checker.sv
// concurrent checks on the link between the bit timer core and device
`timescale 1ns/1ps
module btr_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// core side
	input wire logic gie,
	input wire logic instr_busy,
	input wire logic instr_done,
	input wire logic button_cmd,
	// device side
	input wire logic pc_push,
	input wire logic pc_pop,
	input wire logic isr_start,
	input wire logic core_run,
	input wire logic fetch_start
);
	// =========================
	// helpers
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// cleared by a return, set again by the next retired instruction
	logic instr_seen_q;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			instr_seen_q <= 1'b1;
		else if (pc_pop)
			instr_seen_q <= 1'b0;
		else if (instr_done)
			instr_seen_q <= 1'b1;
	sequence s_push4;
		pc_push [*4] ##1 !pc_push;
	endsequence
	sequence s_pop4;
		pc_pop [*4] ##1 !pc_pop;
	endsequence
	// =========================
	// properties
	a_push_four: assert property ($rose(pc_push) |-> s_push4)
		else $error("entry push length wrong");
	a_jump_start: assert property ($fell(pc_push) |-> !isr_start ##[1:2] isr_start)
		else $error("handler start not after jump");
	a_busy_defers: assert property (instr_busy && !pc_push |=> !pc_push)
		else $error("entry during busy instruction");
	a_pop_four: assert property ($rose(pc_pop) |-> s_pop4)
		else $error("return pop length wrong");
	a_instr_between: assert property ($rose(pc_push) |-> instr_seen_q)
		else $error("no instruction between handlers");
	a_gie_gates: assert property ($rose(pc_push) |-> core_run && ($past(gie) || $past(gie, 2)))
		else $error("entry without global enable");
	a_fetch_run: assert property (fetch_start |-> core_run && !$past(core_run))
		else $error("fetch not at run start");
	a_button_stop: assert property (button_cmd && core_run |-> ##[1:2] !core_run)
		else $error("button reset not entered");
endmodule : btr_checker

// >>> tb/tb_bit_timer_reset_irq.sv
// self-checking bench for the bit timer core and device joined over the link
`timescale 1ns/1ps
module tb_bit_timer_reset_irq;
	// =========================
	// signals
	localparam int POR = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pulse_input_pin = 1'b0;
	logic external_reset_n = 1'b1;
	logic watchdog_reset = 1'b0;
	logic brownout = 1'b0;
	logic button_pin = 1'b0;
	logic rf_key;
	logic [31:0] rdat;
	logic serr;
	logic [31:0] seed = 32'h2E1A1959;
	logic key_q[$];
	logic rec = 1'b0;
	logic [15:0] w0s[4] = '{16'h0000, 16'hC123, 16'h940E, 16'h940D};
	int num_errors = 0;
	int n_tests = 0;
	int n2 = 0;
	int n4 = 0;
	int ticks = 0;
	int t0;
	int w;
	btr_link_if lnk (.pclk, .presetn);
	btr_device #(.POR_DELAY(POR)) btr_device_i (.lnk, .pulse_input_pin, .external_reset_n,
		.watchdog_reset, .brownout, .button_pin, .rf_key);
	btr_core btr_core_i (.lnk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr);
	btr_checker btr_checker_i (.pclk, .presetn, .gie(lnk.gie), .instr_busy(lnk.instr_busy),
		.instr_done(lnk.instr_done), .button_cmd(lnk.button_cmd), .pc_push(lnk.pc_push),
		.pc_pop(lnk.pc_pop), .isr_start(lnk.isr_start), .core_run(lnk.core_run),
		.fetch_start(lnk.fetch_start));
	always #12.5 pclk = ~pclk;
	// key level and handler entries, sampled before each edge settles
	always @(posedge pclk)
	begin
		ticks++;
		if (rec)
			key_q.push_back(rf_key);
		if (lnk.isr_start === 1'b1 && lnk.irq_vector === btr_pkg::VEC_TRANSMISSION_COMPLETE)
			n2++;
		if (lnk.isr_start === 1'b1 && lnk.irq_vector === btr_pkg::VEC_BUFEMPTY)
			n4++;
	end
	// =========================
	// tasks
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("wrong value %s: expected %0h, seen %0h", nm, exp, got);
			num_errors++;
		end
	endtask : check
	// idle edge at the end so psel is never assigned twice in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic raw(input logic [1:0] a);
		apb(1'b1, btr_pkg::H_RAW, {21'h0, 1'b1, a, 8'h00});
		cyc(2);
		apb(1'b0, btr_pkg::H_RAW, 32'h0);
	endtask : raw
	// keying model: bit k of bits owns samples k*(cv+1) .. k*(cv+1)+cv
	task automatic run(input logic [5:0] ctl, input int cv, input logic [31:0] bits, input int n);
		int f;
		int bad;
		int ones;
		int slot;
		f = -1;
		bad = 0;
		ones = 0;
		slot = (n + 1) * (cv + 1);
		apb(1'b1, btr_pkg::H_CVAL, 32'(cv));
		apb(1'b1, btr_pkg::H_BITS, bits);
		apb(1'b1, btr_pkg::H_LEN, 32'(n));
		key_q.delete();
		n2 = 0;
		n4 = 0;
		rec = 1'b1;
		apb(1'b1, btr_pkg::H_CTRL, {26'h0, ctl});
		cyc(slot + 80);
		rec = 1'b0;
		foreach (key_q[i])
		begin
			if (f < 0 && key_q[i] === 1'b1)
				f = i;
			if (key_q[i] !== 1'b0)
				ones++;
		end
		if (ctl[1:0] == 2'h1)
		begin
			for (int i = 0; i < slot + 40; i++)
				if (f < 0 || key_q[f + i] !== ((i < slot) ? bits[i / (cv + 1)] : 1'b0))
					bad++;
			check("slot keying", 0, bad);
			check("empty events", ctl[2] ? n + 1 : 0, n4);
		end
		else
			check("generic key", 0, ones);
		check("done events", ctl[2] ? 1 : 0, n2);
	endtask : run
	// =========================
	// sequence
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t0 = ticks;
		apb(1'b1, btr_pkg::H_WORD0, 32'hC000);
		cyc(POR - 8);
		check("early run", 0, lnk.core_run);
		for (int i = 0; i < 40 && lnk.core_run !== 1'b1; i++)
			cyc(1);
		w = ticks - t0;
		check("power-on delay", 1, w >= POR && w <= POR + 3);
		apb(1'b0, 8'h1C, 32'h0);
		check("unmapped error", 1, serr);
		run(6'h0D, 40 + rnd() % 24, rnd() | 32'h1, 3);
		run(6'h0D, 256 + rnd() % 64, rnd() | 32'h1, 1);
		run(6'h29, 45, 32'h1, 0);
		raw(2'h2);
		check("polled flags", 8'h05, rdat[7:0]);
		apb(1'b1, btr_pkg::H_RAW, 32'h201);
		raw(2'h2);
		check("flag0 cleared", 8'h04, rdat[7:0]);
		// global enable on while an instruction is busy: entry must wait
		apb(1'b1, btr_pkg::H_CTRL, 32'h25);
		n2 = 0;
		n4 = 0;
		cyc(40);
		check("busy defers", 0, n2 + n4);
		apb(1'b1, btr_pkg::H_CTRL, 32'h05);
		cyc(120);
		check("busy released", 1, n2);
		check("no empty event", 0, n4);
		apb(1'b1, btr_pkg::H_RAW, 32'h205);
		raw(2'h2);
		check("flags cleared", 8'h00, rdat[7:0]);
		run(6'h0F, 40, 32'h0, 0);
		apb(1'b1, btr_pkg::H_CTRL, 32'hA);
		cyc(5);
		pulse_input_pin <= 1'b1;
		cyc(4);
		raw(2'h0);
		check("rise data", 1, rdat[0]);
		t0 = ticks;
		cyc(20 + rnd() % 300);
		pulse_input_pin <= 1'b0;
		// restart is one edge after the rise; 12 edges pass before t0
		w = ticks - t0 + 11;
		cyc(3);
		raw(2'h1);
		t0 = rdat[7:0];
		raw(2'h0);
		check("fall data", 0, rdat[0]);
		t0 = t0 + 256 * rdat[7:6];
		// tick counter may be read on either side of its own edge update
		check("pulse width", 1, t0 >= w - 1 && t0 <= w + 1);
		foreach (w0s[i])
		begin
			apb(1'b1, btr_pkg::H_WORD0, {16'h0, w0s[i]});
			watchdog_reset <= 1'b1;
			cyc(1);
			watchdog_reset <= 1'b0;
			cyc(8);
			check("run after restart", w0s[i][15:12] == 4'hC ||
				(w0s[i][15:9] == 7'h4A && w0s[i][3:1] == 3'h6), lnk.core_run);
		end
		external_reset_n <= 1'b0;
		cyc(4);
		check("ext ready", 1, lnk.reg_ready);
		check("ext halt", 0, lnk.core_run);
		external_reset_n <= 1'b1;
		brownout <= 1'b1;
		cyc(30);
		check("brownout halt", 0, lnk.core_run);
		brownout <= 1'b0;
		cyc(6);
		check("warm reboot", 1, lnk.core_run);
		apb(1'b1, btr_pkg::H_CTRL, 32'h10);
		cyc(20);
		check("button halt", 0, lnk.core_run);
		button_pin <= 1'b1;
		cyc(1);
		button_pin <= 1'b0;
		cyc(3);
		check("button wake", 1, lnk.core_run);
		report_and_stop();
	end
	// the sequence needs about 2000 cycles; 40000 means a hang
	initial
	begin
		#1000000;
		num_errors++;
		report_and_stop();
	end
endmodule : tb_bit_timer_reset_irq
